// *** common/ctfm_pkg.sv ***
// Constants, field layouts and carrier types of the trace entry formatter.
// Assumes one core clock domain shared by the core, the formatter and the buffer.
package ctfm_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_COUNT   = 12'h008;
  localparam logic [31:0] CTRL_RESET   = 32'h00000000;
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_STAMP_BIT = 2;
  localparam int          CTRL_EN_BIT  = 3;
  localparam int          STAT_DROP_BIT = 0;
  localparam int          STAT_PEND_BIT = 1;

  // ==========================================================
  // Trace modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_LOOP   = 2'h1;
  localparam logic [1:0] MODE_DETAIL = 2'h2;

  // ==========================================================
  // Information byte fields and line counter steps
  localparam logic [1:0] ET_FORCED = 2'h0;
  localparam logic [1:0] ET_VECTOR = 2'h1;
  localparam logic [1:0] ET_SOURCE = 2'h2;
  localparam logic [1:0] ET_DEST   = 2'h3;
  localparam logic [1:0] SZ_8      = 2'h0;
  localparam logic [1:0] SZ_32     = 2'h3;
  localparam logic [2:0] INC_ENTRY = 3'h1;
  localparam logic [2:0] INC_LINE  = 3'h2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [1:0]  kind;
    logic [23:0] pc;
  } ctfm_cof_type;

  typedef struct packed {
    logic        valid;
    logic [23:0] addr;
    logic [1:0]  size;
    logic        read;
    logic [31:0] data;
  } ctfm_acc_type;

  typedef struct packed {
    logic        cmp_match;
    logic        ext_event;
    logic        stamp_ovf;
    logic        pc_valid;
    logic [23:0] pc;
    logic [15:0] stamp;
  } ctfm_evt_type;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_ACK  = 2'b10
  } ctfm_apb_type;

endpackage

// *** rtl/ctfm_formatter.sv ***
// Trace entry formatter with its line FIFO and APB control registers.
// Assumes core, event and buffer inputs are synchronous to pclk.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns

// ==========================================================
// Line FIFO with registered output stage
module ctfm_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          push;
  logic          pop;

  assign in_ready = (count != FULL);
  assign push     = in_valid && in_ready;
  assign pop      = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= CW'(count + CW'(push) - CW'(pop));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ==========================================================
// Formatter top
module ctfm_formatter #(
  parameter int CNT_W = 7,
  parameter int DEPTH = 16
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire ctfm_pkg::ctfm_cof_type cof_in,
  input  wire ctfm_pkg::ctfm_acc_type acc_in,
  input  wire ctfm_pkg::ctfm_evt_type evt_in,
  output logic                       line_valid,
  input  wire logic                  line_ready,
  output logic [63:0]                line_data,
  output logic                       stamp_reset,
  output logic [CNT_W-1:0]           trace_line_counter
);

  // ==========================================================
  // Lane placement, used by the detail line build only
  function automatic logic [31:0] ctfm_place(input logic [1:0] a, input logic [1:0] sz,
                                             input logic [31:0] d);
    logic [31:0] r;
    logic [1:0]  lane;
    r    = '0;
    lane = '0;
    for (int k = 0; k < 4; k++) begin
      if (2'(k) <= sz) begin
        lane = 2'(2'h3 - a - 2'(k));
        r[lane*8 +: 8] = d[(3-k)*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Registers and state
  ctfm_pkg::ctfm_apb_type apb_state;
  logic [31:0]  ctrl;
  logic         drop_flag;
  logic         half_full;
  logic [31:0]  half_entry;
  logic         last_was_src;
  logic [23:0]  last_src;
  logic         pend;
  logic         pend_cmp;
  logic         pend_ovf;

  logic [1:0]   mode;
  logic         stamp_en;
  logic         trace_en;
  logic         nl_mode;
  logic         cause;
  logic         suppress;
  logic         nl_active;
  logic         acc_active;
  logic         ts_due;
  logic [1:0]   ent_type;
  logic [7:0]   cpu_info_byte_nl;
  logic [7:0]   cpu_info_byte_dt;
  logic [7:0]   stamp_info_byte;
  logic [31:0]  entry;
  logic [31:0]  lanes;
  logic         next_push;
  logic [63:0]  next_line;
  logic [2:0]   next_inc;
  logic         ts_write;
  logic         hold_entry;
  logic         fifo_ready;
  logic         accepted;
  logic         wr_fire;
  logic [31:0]  rd_value;
  logic         rd_bad;

  assign mode     = ctrl[ctfm_pkg::CTRL_MODE_LSB +: 2];
  assign stamp_en = ctrl[ctfm_pkg::CTRL_STAMP_BIT];
  assign trace_en = ctrl[ctfm_pkg::CTRL_EN_BIT];
  assign nl_mode  = (mode == ctfm_pkg::MODE_NORMAL) || (mode == ctfm_pkg::MODE_LOOP);

  // ==========================================================
  // Normal and loop entry build
  assign ent_type = cof_in.valid ? cof_in.kind : ctfm_pkg::ET_FORCED;
  assign cpu_info_byte_nl  = {ent_type, 2'h0, evt_in.cmp_match, evt_in.ext_event,
                     1'b0, evt_in.stamp_ovf};
  assign entry    = {cpu_info_byte_nl, cof_in.valid ? cof_in.pc : evt_in.pc};
  assign cause    = cof_in.valid || evt_in.ext_event || evt_in.cmp_match
                    || (stamp_en && evt_in.stamp_ovf);
  // Only a bare source repeat is filtered; a forced cause keeps it visible
  assign suppress = (mode == ctfm_pkg::MODE_LOOP) && cof_in.valid
                    && (cof_in.kind == ctfm_pkg::ET_SOURCE) && last_was_src
                    && (cof_in.pc == last_src) && !evt_in.ext_event
                    && !evt_in.cmp_match && !evt_in.stamp_ovf;
  assign nl_active = trace_en && nl_mode && cause && !suppress;

  // ==========================================================
  // Detail entry build
  assign acc_active = trace_en && (mode == ctfm_pkg::MODE_DETAIL) && acc_in.valid;
  assign cpu_info_byte_dt    = {acc_in.size, acc_in.read, 5'h00};
  assign lanes      = ctfm_place(acc_in.addr[1:0], acc_in.size, acc_in.data);
  assign ts_due     = trace_en && stamp_en && (mode == ctfm_pkg::MODE_DETAIL)
                      && !acc_in.valid
                      && (pend || evt_in.cmp_match || evt_in.stamp_ovf);
  assign stamp_info_byte      = {4'h0, pend_cmp || evt_in.cmp_match, evt_in.pc_valid, 1'b1,
                       pend_ovf || evt_in.stamp_ovf};

  always_comb begin
    next_push  = 1'b0;
    next_line  = '0;
    next_inc   = '0;
    ts_write   = 1'b0;
    hold_entry = 1'b0;
    if (nl_active) begin
      if (stamp_en) begin
        next_push = 1'b1;
        next_line = {evt_in.stamp, 16'h0000, entry};
        next_inc  = ctfm_pkg::INC_LINE;
      end else if (half_full) begin
        next_push = 1'b1;
        next_line = {entry, half_entry};
        next_inc  = ctfm_pkg::INC_ENTRY;
      end else begin
        hold_entry = 1'b1;
        next_inc   = ctfm_pkg::INC_ENTRY;
      end
    end else if (acc_active) begin
      next_push = 1'b1;
      next_line = {lanes, cpu_info_byte_dt, acc_in.addr};
      next_inc  = ctfm_pkg::INC_LINE;
    end else if (ts_due) begin
      next_push = 1'b1;
      next_line = {evt_in.stamp, 16'h0000, stamp_info_byte,
                   evt_in.pc_valid ? evt_in.pc : 24'h000000};
      next_inc  = ctfm_pkg::INC_LINE;
      ts_write  = 1'b1;
    end
  end

  // A full FIFO drops the line; the core is never held off
  assign accepted = !next_push || fifo_ready;

  ctfm_fifo #(
    .W     (64),
    .DEPTH (DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (next_push),
    .in_ready  (fifo_ready),
    .in_data   (next_line),
    .out_valid (line_valid),
    .out_ready (line_ready),
    .out_data  (line_data)
  );

  // ==========================================================
  // Line counter and stamp reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trace_line_counter <= '0;
    end else if (accepted) begin
      trace_line_counter <= CNT_W'(trace_line_counter + CNT_W'(next_inc));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stamp_reset <= 1'b0;
    end else begin
      stamp_reset <= ts_write && fifo_ready;
    end
  end

  // ==========================================================
  // Half-line hold and loop history
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_full  <= 1'b0;
      half_entry <= '0;
    end else if (!trace_en || !nl_mode || stamp_en) begin
      half_full <= 1'b0;
    end else if (hold_entry) begin
      half_full  <= 1'b1;
      half_entry <= entry;
    end else if (nl_active && fifo_ready) begin
      half_full <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_was_src <= 1'b0;
      last_src     <= '0;
    end else if (nl_active && accepted) begin
      last_was_src <= (ent_type == ctfm_pkg::ET_SOURCE);
      last_src     <= entry[23:0];
    end
  end

  // ==========================================================
  // Pending timestamp line after a detail data line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend     <= 1'b0;
      pend_cmp <= 1'b0;
      pend_ovf <= 1'b0;
    end else if (acc_active && stamp_en) begin
      pend     <= 1'b1;
      pend_cmp <= evt_in.cmp_match;
      pend_ovf <= evt_in.stamp_ovf;
    end else begin
      pend     <= 1'b0;
      pend_cmp <= 1'b0;
      pend_ovf <= 1'b0;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  assign wr_fire = psel && penable && pready && pwrite;

  always_comb begin
    rd_value = '0;
    rd_bad   = 1'b0;
    case (paddr)
      ctfm_pkg::ADDR_CTRL:   rd_value = ctrl;
      ctfm_pkg::ADDR_STATUS: rd_value = {30'h0, pend, drop_flag};
      ctfm_pkg::ADDR_COUNT:  rd_value = 32'(trace_line_counter);
      default:               rd_bad   = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_state <= ctfm_pkg::APB_IDLE;
      pready    <= 1'b0;
      prdata    <= '0;
      pslverr   <= 1'b0;
    end else begin
      case (apb_state)
        ctfm_pkg::APB_IDLE: begin
          if (psel && penable) begin
            apb_state <= ctfm_pkg::APB_ACK;
            pready    <= 1'b1;
            prdata    <= pwrite ? 32'h00000000 : rd_value;
            pslverr   <= rd_bad;
          end
        end
        ctfm_pkg::APB_ACK: begin
          apb_state <= ctfm_pkg::APB_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default: begin
          apb_state <= ctfm_pkg::APB_IDLE;
          pready    <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= ctfm_pkg::CTRL_RESET;
    end else if (wr_fire && (paddr == ctfm_pkg::ADDR_CTRL)) begin
      ctrl <= {28'h0, pwdata[3:0]};
    end
  end

  // A drop in the clearing cycle keeps the flag set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_flag <= 1'b0;
    end else if (!accepted) begin
      drop_flag <= 1'b1;
    end else if (wr_fire && (paddr == ctfm_pkg::ADDR_STATUS)
                 && pwdata[ctfm_pkg::STAT_DROP_BIT]) begin
      drop_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  a_cpu_info_byte_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
    nl_active |-> (entry[29:28] == 2'h0) && (entry[25] == 1'b0))
    else $error("info byte reserved bits set");
  a_type_forced: assert property (@(posedge pclk) disable iff (!presetn)
    (nl_active && !cof_in.valid) |-> (entry[31:30] == ctfm_pkg::ET_FORCED))
    else $error("forced entry type wrong");
  a_cmp_forces: assert property (@(posedge pclk) disable iff (!presetn)
    (trace_en && nl_mode && evt_in.cmp_match) |-> nl_active && entry[27])
    else $error("comparator match entry missing");
  a_ext_flag: assert property (@(posedge pclk) disable iff (!presetn)
    nl_active |-> (entry[26] == evt_in.ext_event))
    else $error("external event flag wrong");
  a_loop_drop_src: assert property (@(posedge pclk) disable iff (!presetn)
    (trace_en && mode == ctfm_pkg::MODE_LOOP && !evt_in.ext_event && !evt_in.cmp_match
     && !evt_in.stamp_ovf && cof_in.valid && cof_in.kind == ctfm_pkg::ET_SOURCE
     && last_was_src && cof_in.pc == last_src) |-> !nl_active)
    else $error("repeated source not filtered");
  a_loop_keep_dst: assert property (@(posedge pclk) disable iff (!presetn)
    (trace_en && nl_mode && cof_in.valid && cof_in.kind != ctfm_pkg::ET_SOURCE)
    |-> nl_active)
    else $error("destination or vector filtered");
  a_detail_count: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_active && fifo_ready) |=>
    (trace_line_counter == CNT_W'($past(trace_line_counter) + 2)))
    else $error("detail counter step wrong");
  a_ts_suppress: assert property (@(posedge pclk) disable iff (!presetn)
    (pend && acc_in.valid) |-> !ts_write)
    else $error("timestamp line not suppressed");
  a_stamp_reset: assert property (@(posedge pclk) disable iff (!presetn)
    stamp_reset |-> $past(ts_write) && !$past(acc_active))
    else $error("stamp reset without timestamp line");
  a_stamp_info_byte_form: assert property (@(posedge pclk) disable iff (!presetn)
    ts_write |-> (next_line[31:28] == 4'h0) && next_line[25]
                 && (next_line[26] == evt_in.pc_valid))
    else $error("stamp info byte malformed");
  a_lane_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_active && acc_in.size == ctfm_pkg::SZ_8 && acc_in.addr[1:0] == 2'h0)
    |-> (next_line[55:32] == 24'h000000) && (next_line[63:56] == acc_in.data[31:24]))
    else $error("byte lane placement wrong");

endmodule

// *** tb/ctfm_buffer_model.sv ***
// Trace buffer memory model standing at the formatter's line output.
// Assumes the bench clears the capture queue between tests.
`timescale 1ns/1ns
module ctfm_buffer_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        line_valid,
  input  wire logic [63:0] line_data,
  output logic             line_ready,
  input  wire logic        stall,
  input  wire logic        slow
);
  logic [63:0] got [$];

  // ==========================================================
  // Line acceptance; slow mode takes at most every other cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ready <= 1'b0;
    end else begin
      if (line_valid && line_ready) begin
        got.push_back(line_data);
      end
      line_ready <= !stall && !(slow && line_ready);
    end
  end
endmodule

// *** tb/ctfm_formatter_tb_top.sv ***
// Self-checking bench for the trace entry formatter.
// Assumes the buffer model captures every accepted line in order.
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module ctfm_formatter_tb_top;
  localparam int CW = 7;
  logic                   pclk;
  logic                   presetn;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [11:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  ctfm_pkg::ctfm_cof_type cof_in;
  ctfm_pkg::ctfm_acc_type acc_in;
  ctfm_pkg::ctfm_evt_type evt_in;
  logic                   line_valid;
  logic                   line_ready;
  logic [63:0]            line_data;
  logic                   stamp_reset;
  logic [CW-1:0]          trace_line_counter;
  logic                   stall;
  logic                   slow;
  logic [31:0]            rd;
  logic                   err;
  int                     errors;
  int                     checked;
  int                     cnt0;
  int                     stamps;

  ctfm_formatter #(.CNT_W(CW), .DEPTH(16)) ctfm_formatter_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cof_in(cof_in), .acc_in(acc_in), .evt_in(evt_in), .line_valid(line_valid),
    .line_ready(line_ready), .line_data(line_data), .stamp_reset(stamp_reset),
    .trace_line_counter(trace_line_counter));

  ctfm_buffer_model ctfm_buffer_model_i (
    .pclk(pclk), .presetn(presetn), .line_valid(line_valid), .line_data(line_data),
    .line_ready(line_ready), .stall(stall), .slow(slow));

  always #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (stamp_reset === 1'b1) begin
      stamps++;
    end
  end

  // ==========================================================
  // Helpers
  function automatic logic [63:0] g(input int i);
    return ctfm_buffer_model_i.got[i];
  endfunction

  function automatic logic [CW-1:0] cx(input int d);
    return CW'(cnt0 + d);
  endfunction

  function automatic ctfm_pkg::ctfm_cof_type cf(input logic [1:0] k, input logic [23:0] pc);
    return {1'b1, k, pc};
  endfunction

  function automatic ctfm_pkg::ctfm_evt_type ev(input logic c, input logic x, input logic o,
                                                input logic v, input logic [23:0] pc,
                                                input logic [15:0] st);
    return {c, x, o, v, pc, st};
  endfunction

  // Lanes from the address offset, descending with wrap; untouched lanes zero
  function automatic logic [63:0] dl(input ctfm_pkg::ctfm_acc_type a);
    logic [31:0] ln;
    int          lane;
    ln = '0;
    for (int k = 0; k <= int'(a.size); k++) begin
      lane = (int'(a.addr[1:0]) + k) % 4;
      ln[(3 - lane) * 8 +: 8] = a.data[(3 - k) * 8 +: 8];
    end
    return {ln, a.size, a.read, 5'h0, a.addr};
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // No fixed latency assumed: wait for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge, so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask

  task automatic drv(input ctfm_pkg::ctfm_cof_type c, input ctfm_pkg::ctfm_acc_type a,
                     input ctfm_pkg::ctfm_evt_type e);
    cof_in <= c;
    acc_in <= a;
    evt_in <= e;
    @(posedge pclk);
  endtask

  task automatic idle(input int n);
    repeat (n) drv('0, '0, '0);
  endtask

  task automatic wait_lines(input int n);
    int t;
    for (t = 0; t < 300 && ctfm_buffer_model_i.got.size() < n; t++) begin
      @(posedge pclk);
    end
    if (t >= 300) begin
      errors++;
      end_sim();
    end
  endtask

  task automatic start(input logic [31:0] c);
    apb(1'b1, ctfm_pkg::ADDR_CTRL, c);
    ctfm_buffer_model_i.got.delete();
    cnt0 = int'(trace_line_counter);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    apb(1'b0, ctfm_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, ctfm_pkg::CTRL_RESET)
    apb(1'b1, ctfm_pkg::ADDR_CTRL, 32'hfffffff7);
    apb(1'b0, ctfm_pkg::ADDR_CTRL, 32'h0);
    `CHK(rd, 32'h00000007)
    apb(1'b1, ctfm_pkg::ADDR_COUNT, 32'h00000055);
    apb(1'b0, ctfm_pkg::ADDR_COUNT, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, 12'h00c, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("test regs done");
  endtask

  task automatic t_normal();
    start(32'h00000008);
    drv(cf(ctfm_pkg::ET_SOURCE, 24'h00a0b0), '0, '0);
    drv(cf(ctfm_pkg::ET_DEST, 24'h00c0d0), '0, ev(1, 0, 0, 0, 24'h0, 16'h0));
    drv(cf(ctfm_pkg::ET_VECTOR, 24'h00fff2), '0, '0);
    drv('0, '0, ev(0, 1, 0, 0, 24'h001234, 16'h0));
    idle(3);
    wait_lines(2);
    `CHK(g(0), {8'hc8, 24'h00c0d0, 8'h80, 24'h00a0b0})
    `CHK(g(1), {8'h04, 24'h001234, 8'h40, 24'h00fff2})
    start(32'h0000000c);
    drv(cf(ctfm_pkg::ET_DEST, 24'h0003c0), '0, ev(0, 0, 1, 0, 24'h0, 16'h5a5a));
    idle(3);
    wait_lines(1);
    `CHK(g(0), {16'h5a5a, 16'h0, 8'hc1, 24'h0003c0})
    $display("test normal done");
  endtask

  task automatic t_loop();
    start(32'h00000009);
    drv(cf(ctfm_pkg::ET_SOURCE, 24'h000100), '0, '0);
    drv(cf(ctfm_pkg::ET_SOURCE, 24'h000100), '0, '0);
    drv(cf(ctfm_pkg::ET_DEST, 24'h000200), '0, '0);
    drv(cf(ctfm_pkg::ET_DEST, 24'h000200), '0, '0);
    drv(cf(ctfm_pkg::ET_VECTOR, 24'h000300), '0, '0);
    drv(cf(ctfm_pkg::ET_VECTOR, 24'h000300), '0, '0);
    drv(cf(ctfm_pkg::ET_SOURCE, 24'h000400), '0, '0);
    idle(3);
    wait_lines(3);
    `CHK(g(0), {8'hc0, 24'h000200, 8'h80, 24'h000100})
    `CHK(g(1), {8'h40, 24'h000300, 8'hc0, 24'h000200})
    `CHK(g(2), {8'h80, 24'h000400, 8'h40, 24'h000300})
    $display("test loop done");
  endtask

  task automatic t_detail();
    ctfm_pkg::ctfm_acc_type q [16];
    start(32'h0000000a);
    for (int i = 0; i < 16; i++) begin
      q[i] = '{valid: 1'b1, addr: 24'h5a5a50 | 24'(i % 4), size: 2'(i / 4),
               read: i[0], data: 32'hd1d2d3d4};
      drv('0, q[i], '0);
    end
    idle(3);
    wait_lines(16);
    for (int i = 0; i < 16; i++) begin
      `CHK(g(i), dl(q[i]))
    end
    `CHK(trace_line_counter, cx(32))
    $display("test detail done");
  endtask

  task automatic t_stamp();
    ctfm_pkg::ctfm_acc_type a;
    ctfm_pkg::ctfm_acc_type b;
    int                     s0;
    a = '{valid: 1'b1, addr: 24'h102000, size: ctfm_pkg::SZ_32, read: 1'b1,
          data: 32'h11223344};
    b = a;
    b.addr = 24'h102005;
    b.read = 1'b0;
    start(32'h0000000e);
    s0 = stamps;
    drv('0, a, '0);
    drv('0, '0, ev(0, 0, 0, 1, 24'h00abcd, 16'h1234));
    idle(3);
    wait_lines(2);
    `CHK(g(0), dl(a))
    `CHK(g(1), {16'h1234, 16'h0, 8'h06, 24'h00abcd})
    `CHK(stamps - s0, 1)
    `CHK(trace_line_counter, cx(4))
    drv('0, a, '0);
    drv('0, b, '0);
    drv('0, '0, ev(0, 0, 0, 0, 24'h0, 16'h0077));
    idle(3);
    wait_lines(5);
    `CHK(g(3), dl(b))
    `CHK(g(4), {16'h0077, 16'h0, 8'h02, 24'h0})
    `CHK(stamps - s0, 2)
    `CHK(trace_line_counter, cx(10))
    $display("test stamp done");
  endtask

  // Buffer stalls so the FIFO overflows, then drains at half rate
  task automatic t_fifo();
    ctfm_pkg::ctfm_acc_type a;
    int                     n;
    a = '{valid: 1'b1, addr: 24'h000013, size: 2'h1, read: 1'b1, data: 32'ha1b2c3d4};
    start(32'h0000000a);
    stall <= 1'b1;
    repeat (20) drv('0, a, '0);
    idle(2);
    apb(1'b0, ctfm_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[ctfm_pkg::STAT_DROP_BIT], 1'b1)
    slow <= 1'b1;
    stall <= 1'b0;
    wait_lines(16);
    idle(40);
    n = ctfm_buffer_model_i.got.size();
    `CHK(n >= 16 && n < 20, 1'b1)
    `CHK(g(n - 1), dl(a))
    `CHK(trace_line_counter, cx(2 * n))
    apb(1'b1, ctfm_pkg::ADDR_STATUS, 32'h00000001);
    apb(1'b0, ctfm_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[ctfm_pkg::STAT_DROP_BIT], 1'b0)
    slow <= 1'b0;
    $display("test fifo done");
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cof_in = '0;
    acc_in = '0;
    evt_in = '0;
    stall = 1'b0;
    slow = 1'b0;
    errors = 0;
    checked = 0;
    stamps = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_normal();
    t_loop();
    t_detail();
    t_stamp();
    t_fifo();
    end_sim();
  end
endmodule
